// >>> pkg/dacsc_map.svh
`ifndef DACSC_MAP_SVH
`define DACSC_MAP_SVH

// ----------------------------------------------------------------
// frame layout and timing
// ----------------------------------------------------------------
`define DACSC_FRAME_BITS 24
`define DACSC_CNT_W 5
`define DACSC_FRAME_LEN 5'h18
`define DACSC_CNT_MAX 5'h1F
`define DACSC_DATA_W 16

// ----------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------
`define DACSC_REG_FUNC 3'h0
`define DACSC_REG_DATA 3'h2
`define DACSC_REG_CGAIN 3'h3
`define DACSC_REG_FGAIN 3'h4
`define DACSC_REG_OFFS 3'h5

// ----------------------------------------------------------------
// channel select and function register operations
// ----------------------------------------------------------------
`define DACSC_CH_BOTH 3'h4
`define DACSC_FN_NOP 3'h0
`define DACSC_FN_CTRL 3'h1
`define DACSC_FN_CLEAR 3'h4
`define DACSC_FN_LOAD 3'h5

// ----------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------
`define DACSC_FGAIN_W 6
`define DACSC_FUNC_W 6
`define DACSC_FUNC_RST 6'h00
`define DACSC_PIN_DIS_BIT 0
`define DACSC_CLEAR_CODE 16'h0000
`define DACSC_RD_PAD 8'h00

`endif

// >>> pkg/dacsc_pkg.sv
package dacsc_pkg;

    // one serial frame, msb first on the wire
    typedef struct packed {
        logic rw;
        logic rsvd;
        logic [2:0] reg_sel;
        logic [2:0] ch_sel;
        logic [15:0] data;
    } dacsc_frame_t;

    // pin levels after synchronisation
    typedef struct packed {
        logic fs_n;
        logic load_strobe_n_n;
        logic clr_n;
        logic coding;
    } dacsc_pins_t;

endpackage : dacsc_pkg

// >>> hw/dacsc_top.sv
// How it works
// - frame ended before 24 falling edges is flagged invalid and discarded
// - standalone frame with over 24 edges is invalid and discarded
// - falling frame select starts a frame; shifting begins then
// - rising frame select moves the word into the addressed register
// - extra clocks push oldest shift bits out on serial_out_pin for chaining
// - serial_out_pin changes on rising clock, sampled by receiver on falling
// - after frame select rises, clock edges are ignored until next frame
// - readback needs output_pin_disable clear; it resets clear
// - read frame selects register to read; its data bits ignored
// - frame after a read request shifts selected register out
// - fine gain readback sits in data bits 5 to 0
// - load strobe low during shifting updates addressed output at frame end
// - load strobe high during shifting; its falling edge updates all outputs
// - output value is code, or code with msb inverted in twos complement
// - falling clear pin clears outputs to code zero
// - cleared outputs hold until new value written and loaded
// - clear pin low at power-on loads clear value to outputs
// - clear command frame clears all channels like the pin
// - frame: rw, reserved, register_select, channel_select, 16 data bits
// - register_select zero is function register: no-op, control, clear, load
// - coding_select_pin low selects twos complement, high offset binary
`include "dacsc_map.svh"

module dacsc_top
    import dacsc_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic serial_clock,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic load_strobe_n,
    input wire logic clear_pin_n,
    input wire logic coding_select_pin,
    input wire logic daisy_chain_en,
    output logic output_pin_disable,
    output logic frame_error,
    output logic [NUM_CH-1:0][15:0] dac_value
);

    // ----------------------------------------------------------------
    // link domain, clocked by serial_clock
    // ----------------------------------------------------------------
    logic [23:0] shift_q, rd_word_q;
    logic [4:0] cnt_q;
    logic armed_q, frame_tgl_q, sdo_q, rd_pend_q, func_pin_dis;

    // armed is forced while frame select is high, so a frame with no edges still reads as such
    always_ff @(negedge serial_clock or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            armed_q <= 1'b1;
        end else begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(negedge serial_clock) begin
        if (!frame_sync_n) begin
            if (armed_q) begin
                cnt_q <= 5'h01;
            end else if (cnt_q != `DACSC_CNT_MAX) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // link clock may never run in reset; frame select is high then, so release is safe
    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            frame_tgl_q <= 1'b0;
        end else if (!frame_sync_n && armed_q) begin
            frame_tgl_q <= ~frame_tgl_q;
        end
    end

    // readback word is quasi-static: written by sys_clk while frame select is high
    always_ff @(negedge serial_clock) begin
        if (!frame_sync_n) begin
            if (armed_q && rd_pend_q) begin
                shift_q <= {rd_word_q[22:0], serial_in};
            end else begin
                shift_q <= {shift_q[22:0], serial_in};
            end
        end
    end

    always_ff @(posedge serial_clock or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= shift_q[23];
        end
    end

    // first bit must be on the pin before the first falling edge
    assign serial_out_pin = armed_q ? (rd_pend_q & rd_word_q[23]) : sdo_q;
    assign serial_out_oe = ~frame_sync_n & ~func_pin_dis;

    // ----------------------------------------------------------------
    // synchronisers into sys_clk
    // ----------------------------------------------------------------
    dacsc_pins_t pin_m_q, pin_s_q;
    logic [23:0] shift_m_q, shift_s_q;
    logic [4:0] cnt_m_q, cnt_s_q;
    logic tgl_m_q, tgl_s_q;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pin_m_q <= '{fs_n: 1'b1, load_strobe_n_n: 1'b1, clr_n: 1'b1, coding: 1'b0};
            pin_s_q <= '{fs_n: 1'b1, load_strobe_n_n: 1'b1, clr_n: 1'b1, coding: 1'b0};
        end else begin
            pin_m_q <= '{fs_n: frame_sync_n, load_strobe_n_n: load_strobe_n,
                         clr_n: clear_pin_n, coding: coding_select_pin};
            pin_s_q <= pin_m_q;
        end
    end

    // link words are stable once frame select is high, so a plain double stage suffices
    always_ff @(posedge sys_clk) begin
        shift_m_q <= shift_q;
        shift_s_q <= shift_m_q;
        cnt_m_q <= cnt_q;
        cnt_s_q <= cnt_m_q;
        tgl_m_q <= frame_tgl_q;
        tgl_s_q <= tgl_m_q;
    end

    // ----------------------------------------------------------------
    // edge detection and frame decode
    // ----------------------------------------------------------------
    logic fs_prev_q, load_strobe_n_prev_q, clr_prev_q, tgl_seen_q;
    logic fs_rise, load_strobe_n_fall, clr_fall, had_edges, len_ok, frame_ok;
    dacsc_frame_t frm;
    logic wr_ok, rd_ok, wr_data, wr_cgain, wr_fgain, wr_offs, wr_func;
    logic cmd_clear, cmd_load, clear_any, load_all;
    logic [NUM_CH-1:0] ch_hit;

    // prev values reset high: clear pin held low at power-on reads as a fall
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fs_prev_q <= 1'b1;
            load_strobe_n_prev_q <= 1'b1;
            clr_prev_q <= 1'b1;
        end else begin
            fs_prev_q <= pin_s_q.fs_n;
            load_strobe_n_prev_q <= pin_s_q.load_strobe_n_n;
            clr_prev_q <= pin_s_q.clr_n;
        end
    end

    assign fs_rise = pin_s_q.fs_n & ~fs_prev_q;
    assign load_strobe_n_fall = ~pin_s_q.load_strobe_n_n & load_strobe_n_prev_q;
    assign clr_fall = ~pin_s_q.clr_n & clr_prev_q;
    assign had_edges = tgl_s_q != tgl_seen_q;
    assign len_ok = (cnt_s_q == `DACSC_FRAME_LEN) ||
                    (daisy_chain_en && cnt_s_q > `DACSC_FRAME_LEN);
    assign frame_ok = fs_rise & had_edges & len_ok;
    assign frm = dacsc_frame_t'(shift_s_q);
    assign rd_ok = frame_ok & frm.rw;
    assign wr_ok = frame_ok & ~frm.rw;
    assign wr_data = wr_ok && frm.reg_sel == `DACSC_REG_DATA;
    assign wr_cgain = wr_ok && frm.reg_sel == `DACSC_REG_CGAIN;
    assign wr_fgain = wr_ok && frm.reg_sel == `DACSC_REG_FGAIN;
    assign wr_offs = wr_ok && frm.reg_sel == `DACSC_REG_OFFS;
    assign wr_func = wr_ok && frm.reg_sel == `DACSC_REG_FUNC &&
                     frm.ch_sel == `DACSC_FN_CTRL;
    assign cmd_clear = wr_ok && frm.reg_sel == `DACSC_REG_FUNC &&
                       frm.ch_sel == `DACSC_FN_CLEAR;
    assign cmd_load = wr_ok && frm.reg_sel == `DACSC_REG_FUNC &&
                      frm.ch_sel == `DACSC_FN_LOAD;
    assign clear_any = clr_fall | cmd_clear;
    assign load_all = load_strobe_n_fall | cmd_load;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tgl_seen_q <= 1'b0;
            frame_error <= 1'b0;
        end else begin
            frame_error <= fs_rise & ~frame_ok;
            if (fs_rise) begin
                tgl_seen_q <= tgl_s_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // per channel registers
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0][15:0] data_q, cgain_q, offs_q, out_code_q;
    logic [NUM_CH-1:0][5:0] fgain_q;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_hit[g] = frm.ch_sel == 3'(g) || frm.ch_sel == `DACSC_CH_BOTH;
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                data_q[g] <= `DACSC_CLEAR_CODE;
            end else if (clear_any) begin
                data_q[g] <= `DACSC_CLEAR_CODE;
            end else if (wr_data && ch_hit[g]) begin
                data_q[g] <= frm.data;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                cgain_q[g] <= 16'h0000;
                fgain_q[g] <= 6'h00;
                offs_q[g] <= 16'h0000;
            end else begin
                if (wr_cgain && ch_hit[g]) begin
                    cgain_q[g] <= frm.data;
                end
                if (wr_fgain && ch_hit[g]) begin
                    fgain_q[g] <= frm.data[5:0];
                end
                if (wr_offs && ch_hit[g]) begin
                    offs_q[g] <= frm.data;
                end
            end
        end

        // clear beats a load in the same cycle so a cleared output cannot be overwritten
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                out_code_q[g] <= `DACSC_CLEAR_CODE;
            end else if (clear_any) begin
                out_code_q[g] <= `DACSC_CLEAR_CODE;
            end else if (load_all) begin
                out_code_q[g] <= data_q[g];
            end else if (wr_data && ch_hit[g] && !pin_s_q.load_strobe_n_n) begin
                out_code_q[g] <= frm.data;
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                dac_value[g] <= 16'h0000;
            end else if (pin_s_q.coding) begin
                dac_value[g] <= out_code_q[g];
            end else begin
                dac_value[g] <= {~out_code_q[g][15], out_code_q[g][14:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // function register and readback
    // ----------------------------------------------------------------
    logic [5:0] func_q;
    logic [15:0] rd_val;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            func_q <= `DACSC_FUNC_RST;
        end else if (wr_func) begin
            func_q <= frm.data[5:0];
        end
    end

    assign func_pin_dis = func_q[`DACSC_PIN_DIS_BIT];
    assign output_pin_disable = func_pin_dis;

    always_comb begin
        case (frm.reg_sel)
            `DACSC_REG_FUNC: rd_val = {10'h000, func_q};
            `DACSC_REG_DATA: rd_val = data_q[frm.ch_sel[0]];
            `DACSC_REG_CGAIN: rd_val = cgain_q[frm.ch_sel[0]];
            `DACSC_REG_FGAIN: rd_val = {10'h000, fgain_q[frm.ch_sel[0]]};
            `DACSC_REG_OFFS: rd_val = offs_q[frm.ch_sel[0]];
            default: rd_val = 16'h0000;
        endcase
    end

    // a new request wins over consumption at the same frame end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_pend_q <= 1'b0;
            rd_word_q <= 24'h000000;
        end else if (rd_ok) begin
            rd_pend_q <= 1'b1;
            rd_word_q <= {`DACSC_RD_PAD, rd_val};
        end else if (fs_rise) begin
            rd_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_short_frame;
        fs_rise && had_edges && cnt_s_q < `DACSC_FRAME_LEN |=> frame_error && $stable(data_q);
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame accepted");

    property p_long_frame;
        fs_rise && !daisy_chain_en && cnt_s_q > `DACSC_FRAME_LEN |=> frame_error;
    endproperty
    a_long_frame: assert property (p_long_frame) else $error("long frame accepted");

    property p_data_write;
        wr_data && ch_hit[0] && !clear_any |=> data_q[0] == $past(frm.data);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_indiv_load;
        wr_data && ch_hit[0] && !pin_s_q.load_strobe_n_n && !clear_any && !load_all
        |=> out_code_q[0] == $past(frm.data) ##1 dac_value[0][14:0] == $past(frm.data[14:0], 2);
    endproperty
    a_indiv_load: assert property (p_indiv_load) else $error("individual update missing");

    property p_sim_load;
        load_strobe_n_fall && !clear_any |=> out_code_q == $past(data_q);
    endproperty
    a_sim_load: assert property (p_sim_load) else $error("simultaneous update missing");

    property p_held_output;
        wr_data && pin_s_q.load_strobe_n_n && !load_all && !clear_any |=> $stable(out_code_q);
    endproperty
    a_held_output: assert property (p_held_output) else $error("output moved without load");

    property p_pin_clear;
        clr_fall |=> out_code_q[0] == `DACSC_CLEAR_CODE && data_q[0] == `DACSC_CLEAR_CODE;
    endproperty
    a_pin_clear: assert property (p_pin_clear) else $error("clear pin ignored");

    property p_cmd_clear;
        cmd_clear |=> data_q == '0 && out_code_q == '0;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("clear command ignored");

    property p_coding;
        ##1 $past(pin_s_q.coding) == 1'b0 |->
            dac_value[1] == {~$past(out_code_q[1][15]), $past(out_code_q[1][14:0])};
    endproperty
    a_coding: assert property (p_coding) else $error("twos complement map wrong");

    property p_fgain_read;
        rd_ok && frm.reg_sel == `DACSC_REG_FGAIN && frm.ch_sel == 3'h0
        |=> rd_pend_q && rd_word_q == {18'h00000, $past(fgain_q[0])};
    endproperty
    a_fgain_read: assert property (p_fgain_read) else $error("fine gain readback wrong");

    property p_pin_disable;
        wr_func |=> output_pin_disable == $past(frm.data[0]);
    endproperty
    a_pin_disable: assert property (p_pin_disable) else $error("pin disable not stored");

    c_good_write: cover property (wr_data ##[1:100] load_strobe_n_fall);
    c_readback: cover property (rd_ok ##[1:400] frame_ok && !frm.rw);
    c_clear_pin: cover property (clr_fall);
    c_bad_frame: cover property (frame_error);

endmodule : dacsc_top

// >>> verif/dacsc_host.sv
module dacsc_host (
    output logic serial_clock,
    output logic frame_sync_n,
    output logic serial_in,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // idle state
    // ----------------------------------------------------------------
    initial begin
        serial_clock = 1'b1; // clock stands still high between frames
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end

    // ----------------------------------------------------------------
    // framed transfer
    // ----------------------------------------------------------------
    // uneven halves put the falling and rising link edges at different sys_clk phases
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        frame_sync_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #25 serial_clock = 1'b0;
            rx = {rx[46:0], sdo_line};
            #23 serial_clock = 1'b1;
        end
        #20 frame_sync_n = 1'b1;
        serial_in = ~serial_in;
    endtask : xfer

    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            #25 serial_clock = 1'b0;
            #23 serial_clock = 1'b1;
        end
    endtask : stray

endmodule : dacsc_host

// >>> verif/dacsc_tb_top.sv
`include "dacsc_map.svh"

module dacsc_tb_top
    import dacsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, resetn, load_strobe_n, clear_pin_n, coding_select_pin, daisy_chain_en;
    logic serial_clock, frame_sync_n, serial_in;
    logic serial_out_pin, serial_out_oe, output_pin_disable, frame_error;
    logic [1:0][15:0] dac_value;
    wire logic sdo_line;
    logic [47:0] rxw;
    int bad_count = 0;
    int n_checks = 0;
    int ferr_cnt = 0;
    int n0;

    // no pull on the pin: a released line reads as z
    assign sdo_line = serial_out_oe ? serial_out_pin : 1'bz;

    dacsc_top #(.NUM_CH(2)) dacsc_top_i (
        .sys_clk(sys_clk), .resetn(resetn), .serial_clock(serial_clock),
        .frame_sync_n(frame_sync_n), .serial_in(serial_in),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .load_strobe_n(load_strobe_n), .clear_pin_n(clear_pin_n),
        .coding_select_pin(coding_select_pin), .daisy_chain_en(daisy_chain_en),
        .output_pin_disable(output_pin_disable), .frame_error(frame_error),
        .dac_value(dac_value)
    );

    dacsc_host dacsc_host_i (
        .serial_clock(serial_clock), .frame_sync_n(frame_sync_n),
        .serial_in(serial_in), .sdo_line(sdo_line)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (frame_error === 1'b1) begin
            ferr_cnt++;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    function automatic dacsc_frame_t mk(input logic rw, input logic [2:0] rs,
                                        input logic [2:0] ch, input logic [15:0] d);
        mk = '{rw, 1'b0, rs, ch, d};
    endfunction : mk

    // gap after each frame covers the crossing and the minimum idle time
    task automatic send(input dacsc_frame_t f);
        dacsc_host_i.xfer({24'h000000, f}, 24, rxw);
        cyc(10);
    endtask : send

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk_code(dac_value[0], 16'h8000);
        chk_code(dac_value[1], 16'h8000);
        chk_bit(output_pin_disable, 1'b0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_individual;
        load_strobe_n = 1'b0;
        send(mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h1234));
        chk_code(dac_value[0], 16'h9234);
        send(mk(1'b0, `DACSC_REG_DATA, 3'h1, 16'hFFFF));
        chk_code(dac_value[1], 16'h7FFF);
        chk_code(dac_value[0], 16'h9234);
        $display("t_individual done");
    endtask : t_individual

    task automatic t_simultaneous;
        load_strobe_n = 1'b1;
        send(mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h0001));
        send(mk(1'b0, `DACSC_REG_DATA, 3'h1, 16'h8000));
        chk_code(dac_value[0], 16'h9234);
        chk_code(dac_value[1], 16'h7FFF);
        load_strobe_n = 1'b0;
        cyc(6);
        chk_code(dac_value[0], 16'h8001);
        chk_code(dac_value[1], 16'h0000);
        load_strobe_n = 1'b1;
        send(mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h4000));
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_LOAD, 16'h0000));
        chk_code(dac_value[0], 16'hC000);
        coding_select_pin = 1'b1;
        cyc(6);
        chk_code(dac_value[0], 16'h4000);
        coding_select_pin = 1'b0;
        cyc(6);
        $display("t_simultaneous done");
    endtask : t_simultaneous

    task automatic t_bad_frames;
        n0 = ferr_cnt;
        dacsc_host_i.xfer({24'h000000, mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h5555)}, 23, rxw);
        cyc(10);
        chk_code(dac_value[0], 16'hC000);
        dacsc_host_i.xfer({24'h000000, mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h5555)}, 25, rxw);
        cyc(10);
        dacsc_host_i.stray(30);
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_LOAD, 16'h0000));
        chk_code(dac_value[0], 16'hC000);
        chk_code(16'(ferr_cnt - n0), 16'h0002);
        $display("t_bad_frames done");
    endtask : t_bad_frames

    task automatic t_readback;
        send(mk(1'b0, `DACSC_REG_FGAIN, 3'h0, 16'h00EA));
        send(mk(1'b1, `DACSC_REG_FGAIN, 3'h0, 16'hFFFF));
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_NOP, 16'h0000));
        chk_word(rxw[23:0], 24'h00002A);
        send(mk(1'b0, `DACSC_REG_OFFS, `DACSC_CH_BOTH, 16'hA5C3));
        send(mk(1'b1, `DACSC_REG_OFFS, 3'h1, 16'h0000));
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_NOP, 16'h0000));
        chk_word(rxw[23:0], 24'h00A5C3);
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_CTRL, 16'h0001));
        chk_bit(output_pin_disable, 1'b1);
        send(mk(1'b1, `DACSC_REG_FGAIN, 3'h0, 16'h0000));
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_NOP, 16'h0000));
        chk_word(rxw[23:0], 24'hZZZZZZ);
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_CTRL, 16'h0000));
        chk_bit(output_pin_disable, 1'b0);
        $display("t_readback done");
    endtask : t_readback

    task automatic t_clear;
        clear_pin_n = 1'b0;
        cyc(6);
        chk_code(dac_value[0], 16'h8000);
        chk_code(dac_value[1], 16'h8000);
        clear_pin_n = 1'b1;
        cyc(10);
        chk_code(dac_value[0], 16'h8000);
        send(mk(1'b0, `DACSC_REG_DATA, 3'h1, 16'h0100));
        load_strobe_n = 1'b0;
        cyc(6);
        chk_code(dac_value[1], 16'h8100);
        load_strobe_n = 1'b1;
        coding_select_pin = 1'b1;
        send(mk(1'b0, `DACSC_REG_FUNC, `DACSC_FN_CLEAR, 16'hFFFF));
        chk_code(dac_value[0], 16'h0000);
        chk_code(dac_value[1], 16'h0000);
        coding_select_pin = 1'b0;
        cyc(6);
        $display("t_clear done");
    endtask : t_clear

    task automatic t_daisy;
        daisy_chain_en = 1'b1;
        load_strobe_n = 1'b0;
        dacsc_host_i.xfer({mk(1'b0, `DACSC_REG_DATA, 3'h1, 16'hBEEF),
                           mk(1'b0, `DACSC_REG_DATA, 3'h0, 16'h0F0F)}, 48, rxw);
        cyc(10);
        chk_word(rxw[23:0], 24'h11BEEF);
        chk_code(dac_value[0], 16'h8F0F);
        chk_code(dac_value[1], 16'h8000);
        daisy_chain_en = 1'b0;
        n0 = ferr_cnt;
        dacsc_host_i.xfer({24'h000000, 24'h101111}, 48, rxw);
        cyc(10);
        chk_code(dac_value[0], 16'h8F0F);
        chk_code(16'(ferr_cnt - n0), 16'h0001);
        load_strobe_n = 1'b1;
        $display("t_daisy done");
    endtask : t_daisy

    // ----------------------------------------------------------------
    // verdict
    // ----------------------------------------------------------------
    task automatic results;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // all frames together take well under 60 us
    initial begin
        #200us;
        bad_count++;
        results();
    end

    initial begin
        resetn = 1'b0;
        load_strobe_n = 1'b1;
        clear_pin_n = 1'b1;
        coding_select_pin = 1'b0;
        daisy_chain_en = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 resetn = 1'b1;
        cyc(6);
        t_reset();
        t_individual();
        t_simultaneous();
        t_bad_frames();
        t_readback();
        t_clear();
        t_daisy();
        results();
    end

endmodule : dacsc_tb_top
